// >>> pkg/dcap_consts.svh
// Purpose: Shared constants of the debug control access port
// Assumes: 100 MHz system clock, 32-bit access port words
// Notes: Offsets are byte offsets within the access port
// Behaviour
// - Hold bit 1 keeps device in reset
// - Writing 1 starts full erase; 0 ignored
// - Erase status reads 1 while erasing
// - Protection status 0 protected, 1 open
// - Read-only identification word at 0x0FC
// - Power request in off state wakes, flags
// - Debug mode lasts while request held
// - Four-bit parallel trace with trace clock
// - Parallel or serial trace, never both
// - Instruction trace only in parallel mode
// - Serial output shares pin with bit 0
// - Higher-priority interrupts run during breakpoint halt
// - Erase clears memories and lifts protection
`ifndef DCAP_CONSTS_SVH
`define DCAP_CONSTS_SVH

// ==========================================================
// Register offsets
`define DCAP_OFF_HOLD 8'h00
`define DCAP_OFF_ERASE 8'h04
`define DCAP_OFF_ESTAT 8'h08
`define DCAP_OFF_PROT 8'h0c
`define DCAP_OFF_IDENT 8'hfc

// ==========================================================
// Fields and reset values
`define DCAP_BIT_CTRL 0
`define DCAP_WORD_ZERO 32'h0000_0000
`define DCAP_IDF_PORT 7:0
`define DCAP_IDF_CLASS 16:13
`define DCAP_IDF_MAKER 23:17
`define DCAP_IDF_CONT 27:24
`define DCAP_IDF_REV 31:28

// ==========================================================
// Timing
`define DCAP_SYS_PERIOD_NS 10
`define DCAP_TRACE_PERIOD_NS 80
`define DCAP_TRACE_HALF_CYC (`DCAP_TRACE_PERIOD_NS / (2 * `DCAP_SYS_PERIOD_NS))
`define DCAP_TRACE_BITS 4

`endif

// >>> pkg/dcap_pkg.sv
// Purpose: Types of the debug control access port
// Assumes: Constants come from dcap_consts.svh
// Notes: Types only
`default_nettype none
package dcap_pkg;
  typedef enum logic [0:0] {
    DCAP_ER_IDLE = 1'b0,
    DCAP_ER_BUSY = 1'b1
  } dcap_erase_e;
endpackage
`default_nettype wire

// >>> logic/dcap_sync.sv
// Purpose: Two-stage synchroniser for inputs from the debug link domain
// Assumes: Each bit is stable long enough to be sampled twice
// Notes: First stage feeds only the second stage
`default_nettype none
module dcap_sync #(
  parameter int W = 1
) (
  // Clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> logic/dcap_top.sv
// Purpose: Control access port, debug power mode and trace output
// Assumes: Link signals change near the falling edge of the debug clock
// Notes: Access is taken at the synchronised rising edge of the debug clock
`include "dcap_consts.svh"
`default_nettype none
module dcap_top #(
  parameter int TRACE_HALF = `DCAP_TRACE_HALF_CYC,
  parameter logic [7:0] ID_PORT = 8'h00, // Arbitrary value
  parameter logic [3:0] ID_CLASS = 4'h0, // Arbitrary value
  parameter logic [6:0] ID_MAKER = 7'h00, // Arbitrary value
  parameter logic [3:0] ID_CONT = 4'h0, // Arbitrary value
  parameter logic [3:0] ID_REV = 4'h0 // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Serial debug link, foreign domain
  input wire logic swd_clk,
  input wire logic debug_power_request,
  input wire logic ap_sel,
  input wire logic ap_write,
  input wire logic [7:0] ap_addr,
  input wire logic [31:0] ap_wdata,
  output logic [31:0] ap_rdata,
  output logic ap_done,
  // System control
  input wire logic sys_off,
  input wire logic wake_flag_clr,
  input wire logic protect_active,
  input wire logic erase_done,
  output logic soft_reset_hold,
  output logic erase_start,
  output logic erase_busy,
  output logic debug_mode,
  output logic wake_req,
  output logic debug_wake_flag,
  // Breakpoint halt
  input wire logic halt_active,
  input wire logic [2:0] halt_prio,
  input wire logic irq_pending,
  input wire logic [2:0] irq_prio,
  output logic irq_run,
  // Trace sources
  input wire logic trace_serial_mode,
  input wire logic instruction_trace_valid,
  input wire logic [3:0] instruction_trace_data,
  output logic instruction_trace_ready,
  input wire logic instrumentation_trace_valid,
  input wire logic [3:0] instrumentation_trace_data,
  output logic instrumentation_trace_ready,
  // Trace pins
  output logic [3:0] trace_pin_out,
  output logic [3:0] trace_pin_oe,
  output logic trace_clock_output,
  output logic trace_clock_oe
);
  localparam int HW = $clog2(TRACE_HALF + 1);
  localparam logic [31:0] IDENT_WORD = {ID_REV, ID_CONT, ID_MAKER, ID_CLASS, 5'h00, ID_PORT};

  // ==========================================================
  // Link sampling
  logic [43:0] link_q;
  logic swd_q, pwr_q, sel_q, wr_q, swd_prev_r, pwr_prev_r;
  logic [7:0] addr_q;
  logic [31:0] wdata_q;
  logic take, pwr_rise;

  dcap_sync #(.W(44)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .d({swd_clk, debug_power_request, ap_sel, ap_write, ap_addr, ap_wdata}),
    .q(link_q)
  );
  assign {swd_q, pwr_q, sel_q, wr_q, addr_q, wdata_q} = link_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      swd_prev_r <= 1'b0;
      pwr_prev_r <= 1'b0;
    end else if (clk_en) begin
      swd_prev_r <= swd_q;
      pwr_prev_r <= pwr_q;
    end
  end

  // Accesses without a power request are dropped, not queued
  assign take = clk_en & swd_q & ~swd_prev_r & sel_q & pwr_q;
  assign pwr_rise = pwr_q & ~pwr_prev_r;

  // ==========================================================
  // Soft reset hold
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      soft_reset_hold <= 1'b0;
    end else if (take && wr_q && addr_q == `DCAP_OFF_HOLD) begin
      soft_reset_hold <= wdata_q[`DCAP_BIT_CTRL];
    end
  end

  // ==========================================================
  // Erase sequencer
  dcap_pkg::dcap_erase_e er_r;
  logic prot_cleared_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      er_r <= dcap_pkg::DCAP_ER_IDLE;
      erase_start <= 1'b0;
    end else if (clk_en) begin
      erase_start <= 1'b0;
      case (er_r)
        dcap_pkg::DCAP_ER_IDLE: begin
          // A second command while busy is ignored
          if (take && wr_q && addr_q == `DCAP_OFF_ERASE && wdata_q[`DCAP_BIT_CTRL]) begin
            er_r <= dcap_pkg::DCAP_ER_BUSY;
            erase_start <= 1'b1;
          end
        end
        dcap_pkg::DCAP_ER_BUSY: begin
          if (erase_done) begin
            er_r <= dcap_pkg::DCAP_ER_IDLE;
          end
        end
        default: er_r <= dcap_pkg::DCAP_ER_IDLE;
      endcase
    end
  end
  assign erase_busy = (er_r == dcap_pkg::DCAP_ER_BUSY);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prot_cleared_r <= 1'b0;
    end else if (clk_en && erase_busy && erase_done) begin
      prot_cleared_r <= 1'b1;
    end
  end

  // ==========================================================
  // Register reads
  logic prot_open;
  logic [31:0] rd_word;

  assign prot_open = ~protect_active | prot_cleared_r;

  always_comb begin
    rd_word = `DCAP_WORD_ZERO;
    case (addr_q)
      `DCAP_OFF_HOLD: rd_word[`DCAP_BIT_CTRL] = soft_reset_hold;
      `DCAP_OFF_ESTAT: rd_word[`DCAP_BIT_CTRL] = erase_busy;
      `DCAP_OFF_PROT: rd_word[`DCAP_BIT_CTRL] = prot_open;
      `DCAP_OFF_IDENT: rd_word = IDENT_WORD;
      default: rd_word = `DCAP_WORD_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ap_rdata <= `DCAP_WORD_ZERO;
      ap_done <= 1'b0;
    end else if (clk_en) begin
      ap_done <= take;
      if (take && !wr_q) begin
        ap_rdata <= rd_word;
      end
    end
  end

  // ==========================================================
  // Debug power mode and wake
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      debug_mode <= 1'b0;
      wake_req <= 1'b0;
      debug_wake_flag <= 1'b0;
    end else if (clk_en) begin
      debug_mode <= pwr_q;
      wake_req <= pwr_rise & sys_off;
      // Set beats clear so a wake is never lost
      debug_wake_flag <= (pwr_rise & sys_off) | (debug_wake_flag & ~wake_flag_clr);
    end
  end

  // ==========================================================
  // Real-time halt: lower number is higher priority
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_run <= 1'b1;
    end else if (clk_en) begin
      irq_run <= ~halt_active | (irq_pending & (irq_prio < halt_prio));
    end
  end

  // ==========================================================
  // Trace clock divider
  logic [HW-1:0] div_r;
  logic tick;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r <= '0;
      trace_clock_output <= 1'b0;
    end else if (clk_en) begin
      if (div_r == HW'(TRACE_HALF - 1)) begin
        div_r <= '0;
        trace_clock_output <= ~trace_clock_output;
      end else begin
        div_r <= HW'(div_r + 1'b1);
      end
    end
  end
  // Data changes as the trace clock falls, stable for the probe's rising edge
  assign tick = clk_en & trace_clock_output & (div_r == HW'(TRACE_HALF - 1));

  // ==========================================================
  // Trace output
  logic [3:0] sh_r;
  logic [1:0] bit_cnt_r;
  logic par_take_i, par_take_s, ser_load;

  assign par_take_i = tick & ~trace_serial_mode & instruction_trace_valid;
  assign par_take_s = tick & ~trace_serial_mode & ~instruction_trace_valid
    & instrumentation_trace_valid;
  assign ser_load = tick & trace_serial_mode & (bit_cnt_r == 2'd0)
    & instrumentation_trace_valid;
  assign instruction_trace_ready = par_take_i;
  assign instrumentation_trace_ready = par_take_s | ser_load;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sh_r <= 4'h0;
      bit_cnt_r <= 2'd0;
      trace_pin_out <= 4'h0;
    end else if (tick) begin
      if (trace_serial_mode) begin
        // Nibbles leave bit 0 first on the shared pin
        if (ser_load) begin
          sh_r <= instrumentation_trace_data;
          bit_cnt_r <= 2'(`DCAP_TRACE_BITS - 1);
          trace_pin_out <= {3'h0, instrumentation_trace_data[0]};
        end else if (bit_cnt_r != 2'd0) begin
          sh_r <= {1'b0, sh_r[3:1]};
          bit_cnt_r <= bit_cnt_r - 2'd1;
          trace_pin_out <= {3'h0, sh_r[1]};
        end else begin
          trace_pin_out <= 4'h0;
        end
      end else begin
        bit_cnt_r <= 2'd0;
        if (par_take_i) begin
          trace_pin_out <= instruction_trace_data;
        end else if (par_take_s) begin
          trace_pin_out <= instrumentation_trace_data;
        end
      end
    end
  end

  assign trace_pin_oe = trace_serial_mode ? 4'h1 : 4'hf;
  assign trace_clock_oe = ~trace_serial_mode;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_hold;
    take && wr_q && addr_q == `DCAP_OFF_HOLD
      |=> soft_reset_hold == $past(wdata_q[`DCAP_BIT_CTRL]);
  endproperty
  a_hold: assert property (p_hold) else $error("hold bit not written");

  property p_erase_go;
    take && wr_q && addr_q == `DCAP_OFF_ERASE && wdata_q[`DCAP_BIT_CTRL] && !erase_busy
      |=> erase_start && erase_busy;
  endproperty
  a_erase_go: assert property (p_erase_go) else $error("erase not started");

  property p_erase_nop;
    take && wr_q && addr_q == `DCAP_OFF_ERASE && !wdata_q[`DCAP_BIT_CTRL] |=> !erase_start;
  endproperty
  a_erase_nop: assert property (p_erase_nop) else $error("zero write started erase");

  property p_busy_hold;
    erase_busy && !erase_done |=> erase_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_end;
    clk_en && erase_busy && erase_done |=> !erase_busy ##0 prot_open;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("erase end wrong");

  property p_prot_read;
    take && !wr_q && addr_q == `DCAP_OFF_PROT
      |=> ap_done && ap_rdata[`DCAP_BIT_CTRL] == $past(prot_open);
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("protection status wrong");

  property p_ident;
    take && !wr_q && addr_q == `DCAP_OFF_IDENT |=> ap_rdata == IDENT_WORD;
  endproperty
  a_ident: assert property (p_ident) else $error("identification word wrong");

  property p_wake;
    clk_en && pwr_rise && sys_off |=> wake_req && debug_wake_flag;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not flagged");

  property p_mode;
    clk_en |=> debug_mode == $past(pwr_q);
  endproperty
  a_mode: assert property (p_mode) else $error("debug mode wrong");

  property p_serial;
    trace_serial_mode |-> !instruction_trace_ready && trace_pin_oe == 4'h1 && !trace_clock_oe;
  endproperty
  a_serial: assert property (p_serial) else $error("parallel trace in serial mode");

  property p_irq;
    clk_en && halt_active && irq_pending && irq_prio < halt_prio |=> irq_run;
  endproperty
  a_irq: assert property (p_irq) else $error("urgent interrupt blocked");

  c_erase: cover property (erase_busy ##1 !erase_busy);
  c_wake: cover property (wake_req);
  c_serial: cover property (ser_load);
  c_ident: cover property (take && addr_q == `DCAP_OFF_IDENT);
endmodule
`default_nettype wire

// >>> dv/dcap_probe.sv
// Purpose: Debugger probe model on the serial debug link
// Assumes: Tasks are entered at a falling edge of sys_clk
// Notes: Link clock stands still between accesses
`default_nettype none
module dcap_probe (
  // System side
  input wire logic sys_clk,
  input wire logic [31:0] ap_rdata,
  input wire logic ap_done,
  // Link side
  output logic swd_clk,
  output logic debug_power_request,
  output logic ap_sel,
  output logic ap_write,
  output logic [7:0] ap_addr,
  output logic [31:0] ap_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    swd_clk = 1'h0;
    debug_power_request = 1'h0;
    ap_sel = 1'h0;
    ap_write = 1'h0;
    ap_addr = 8'h00;
    ap_wdata = 32'h0000_0000;
  end
  // ======
  // Power request, held for the whole session
  task automatic power(input logic v);
    debug_power_request = v;
  endtask
  // ======
  // One access per link clock pulse: 80 ns setup, 80 ns high, 80 ns hold
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic ok);
    ok = 1'h0;
    rd = 32'h0000_0000;
    ap_sel = 1'h1;
    ap_write = w;
    ap_addr = a;
    ap_wdata = d;
    #80;
    swd_clk = 1'h1;
    repeat (8) begin
      @(negedge sys_clk);
      if (ap_done === 1'h1) begin
        ok = 1'h1;
        rd = ap_rdata;
      end
    end
    swd_clk = 1'h0;
    #80;
    // No pull on these lines, so show a changed value rather than the last one
    ap_sel = 1'h0;
    ap_write = ~w;
    ap_addr = ~a;
    ap_wdata = ~d;
    // Let an edge pass so a following access never re-drives a line in this time step
    @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> dv/test_dcap_top.sv
// Purpose: Self-checking bench of the debug control access port
// Assumes: Probe drives the link, bench drives the system side
// Notes: Data and priorities are random from a fixed seed
`default_nettype none
module test_dcap_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // Signals
  logic sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1;
  logic swd_clk, debug_power_request, ap_sel, ap_write, ap_done, ok, t, si;
  logic [7:0] ap_addr;
  logic [31:0] ap_wdata, ap_rdata, rd, d;
  logic sys_off = 1'h0, wake_flag_clr = 1'h0, protect_active = 1'h1, erase_done = 1'h0;
  logic soft_reset_hold, erase_start, erase_busy, debug_mode, wake_req, debug_wake_flag;
  logic halt_active = 1'h0, irq_pending = 1'h1, irq_run, trace_serial_mode = 1'h0;
  logic [2:0] halt_prio = 3'h0, irq_prio = 3'h0;
  logic instruction_trace_valid = 1'h0, instrumentation_trace_valid = 1'h0;
  logic [3:0] instruction_trace_data = 4'h0, instrumentation_trace_data = 4'h0, nib;
  logic instruction_trace_ready, instrumentation_trace_ready, trace_clock_output;
  logic trace_clock_oe;
  logic [3:0] trace_pin_out, trace_pin_oe;
  int n_fail = 0, compares = 0, cyc = 0, n_start = 0, n_wake = 0, seed = 82666;
  // Identification fields, values arbitrary
  localparam logic [31:0] ID_EXP = {4'h3, 4'h6, 7'h2b, 4'h8, 5'h00, 8'h5a};
  // ======
  // Design and probe
  dcap_top #(.ID_PORT(8'h5a), .ID_CLASS(4'h8), .ID_MAKER(7'h2b), .ID_CONT(4'h6),
    .ID_REV(4'h3)) i_dcap_top (.sys_clk, .rst, .clk_en, .swd_clk,
    .debug_power_request, .ap_sel, .ap_write, .ap_addr, .ap_wdata, .ap_rdata, .ap_done,
    .sys_off, .wake_flag_clr, .protect_active, .erase_done, .soft_reset_hold,
    .erase_start, .erase_busy, .debug_mode, .wake_req, .debug_wake_flag, .halt_active,
    .halt_prio, .irq_pending, .irq_prio, .irq_run, .trace_serial_mode,
    .instruction_trace_valid, .instruction_trace_data, .instruction_trace_ready,
    .instrumentation_trace_valid, .instrumentation_trace_data,
    .instrumentation_trace_ready, .trace_pin_out, .trace_pin_oe, .trace_clock_output,
    .trace_clock_oe);
  dcap_probe i_dcap_probe (.sys_clk, .ap_rdata, .ap_done, .swd_clk,
    .debug_power_request, .ap_sel, .ap_write, .ap_addr, .ap_wdata);
  always #5 sys_clk = ~sys_clk;
  // ======
  // Pulse counters and hang guard
  always @(negedge sys_clk) begin
    if (erase_start === 1'h1) n_start++;
    if (wake_req === 1'h1) n_wake++;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
  end
  // ======
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_dcap_probe.xfer(1'h1, a, v, rd, ok);
    chk("write done", {31'h0, ok}, 32'h0000_0001);
  endtask
  task automatic rdw(input logic [7:0] a);
    i_dcap_probe.xfer(1'h0, a, 32'h0000_0000, rd, ok);
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Waits for a nibble to be taken; notes any instruction take
  task automatic wait_rdy();
    si = 1'h0;
    for (int k = 0; k < 24; k++) begin
      @(negedge sys_clk);
      if (instruction_trace_ready === 1'h1) si = 1'h1;
      if (instruction_trace_ready === 1'h1 || instrumentation_trace_ready === 1'h1) break;
    end
    // Ready is seen mid-cycle; the offer must stand through the taking edge
    @(negedge sys_clk);
    instruction_trace_valid = 1'h0;
    instrumentation_trace_valid = 1'h0;
  endtask
  function automatic logic irq_exp(logic h, logic p, logic [2:0] hp, logic [2:0] ip);
    return !h || (p && (ip < hp));
  endfunction
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ======
  // Main sequence
  initial begin
    cyc_n(5);
    rst = 1'h0;
    cyc_n(2);
    i_dcap_probe.xfer(1'h1, 8'h00, 32'h0000_0001, rd, ok);
    chk("refused done", {31'h0, ok}, 32'h0000_0000);
    chk("hold refused", {31'h0, soft_reset_hold}, 32'h0000_0000);
    i_dcap_probe.power(1'h1);
    cyc_n(5);
    chk("debug mode", {31'h0, debug_mode}, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      d[0] = i[0];
      wr(8'h00, d);
      chk("hold pin", {31'h0, soft_reset_hold}, {31'h0, d[0]});
      rdw(8'h00);
      chk("hold read", rd, {31'h0, d[0]});
    end
    rdw(8'h0c);
    chk("prot on", rd, 32'h0000_0000);
    protect_active = 1'h0;
    rdw(8'h0c);
    chk("prot off", rd, 32'h0000_0001);
    protect_active = 1'h1;
    wr(8'h04, 32'hffff_fffe);
    chk("erase on 0", n_start, 0);
    rdw(8'h04);
    chk("erase read", rd, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    chk("erase start", n_start, 1);
    chk("busy pin", {31'h0, erase_busy}, 32'h0000_0001);
    rdw(8'h08);
    chk("busy read", rd, 32'h0000_0001);
    wr(8'h04, 32'h0000_0001);
    chk("erase again", n_start, 1);
    erase_done = 1'h1;
    cyc_n(1);
    erase_done = 1'h0;
    cyc_n(2);
    chk("ready pin", {31'h0, erase_busy}, 32'h0000_0000);
    rdw(8'h08);
    chk("ready read", rd, 32'h0000_0000);
    rdw(8'h0c);
    chk("prot erased", rd, 32'h0000_0001);
    wr(8'h08, 32'hffff_ffff);
    rdw(8'h08);
    chk("status ro", rd, 32'h0000_0000);
    wr(8'hfc, $random(seed));
    rdw(8'hfc);
    chk("ident", rd, ID_EXP);
    rdw(8'h10);
    chk("unmapped", rd, 32'h0000_0000);
    i_dcap_probe.power(1'h0);
    cyc_n(5);
    chk("normal mode", {31'h0, debug_mode}, 32'h0000_0000);
    sys_off = 1'h1;
    i_dcap_probe.power(1'h1);
    cyc_n(6);
    chk("wake pulses", n_wake, 1);
    chk("wake flag", {31'h0, debug_wake_flag}, 32'h0000_0001);
    sys_off = 1'h0;
    wake_flag_clr = 1'h1;
    cyc_n(1);
    wake_flag_clr = 1'h0;
    cyc_n(1);
    chk("flag clr", {31'h0, debug_wake_flag}, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      {irq_pending, halt_active, halt_prio, irq_prio} = 8'($random(seed));
      cyc_n(3);
      t = irq_exp(halt_active, irq_pending, halt_prio, irq_prio);
      chk("irq run", {31'h0, irq_run}, {31'h0, t});
    end
    t = trace_clock_output;
    cyc_n(4);
    chk("trace clk", {31'h0, trace_clock_output}, {31'h0, ~t});
    chk("par oe", {28'h0, trace_pin_oe}, 32'h0000_000f);
    chk("clk oe", {31'h0, trace_clock_oe}, 32'h0000_0001);
    // Enable low must freeze the trace clock divider
    clk_en = 1'h0;
    t = trace_clock_output;
    cyc_n(8);
    chk("frozen clk", {31'h0, trace_clock_output}, {31'h0, t});
    clk_en = 1'h1;
    cyc_n(1);
    // Pins are ideal here; drive strength stays with software
    for (int i = 0; i < 6; i++) begin
      nib = 4'($random(seed));
      instruction_trace_data = nib;
      instrumentation_trace_data = ~nib;
      instruction_trace_valid = i[0];
      instrumentation_trace_valid = 1'h1;
      wait_rdy();
      cyc_n(1);
      chk("par pins", {28'h0, trace_pin_out}, {28'h0, i[0] ? nib : ~nib});
    end
    trace_serial_mode = 1'h1;
    cyc_n(2);
    chk("ser oe", {28'h0, trace_pin_oe}, 32'h0000_0001);
    chk("ser clk oe", {31'h0, trace_clock_oe}, 32'h0000_0000);
    nib = 4'($random(seed));
    instrumentation_trace_data = nib;
    instruction_trace_valid = 1'h1;
    instrumentation_trace_valid = 1'h1;
    wait_rdy();
    chk("ser no ins", {31'h0, si}, 32'h0000_0000);
    cyc_n(1);
    for (int k = 0; k < 4; k++) begin
      chk("ser bit", {31'h0, trace_pin_out[0]}, {31'h0, nib[k]});
      cyc_n(8);
    end
    final_report();
  end
endmodule
`default_nettype wire
